// file: hw/tofc_pkg.sv
// constants and types for the transmitted-ok frame statistics counter
// assumes an apb master on the same clock as the transmit engine
package tofc_pkg;
  localparam int unsigned TOFC_ADDR_W = 12;
  localparam int unsigned TOFC_DATA_W = 32;
  localparam int unsigned TOFC_TALLY_W = 16;
  localparam int unsigned TOFC_LANES = 2;
  localparam int unsigned TOFC_LANE_W = 8;

  typedef logic [TOFC_TALLY_W-1:0] tofc_tally_t;
  typedef logic [TOFC_ADDR_W-1:0] tofc_addr_t;
  typedef logic [TOFC_DATA_W-1:0] tofc_word_t;

  // register word and its alias words
  localparam tofc_addr_t TOFC_STAT_OFS = 12'h000;
  localparam tofc_addr_t TOFC_CLEAR_OFS = 12'h004;
  localparam tofc_addr_t TOFC_SET_OFS = 12'h008;
  localparam tofc_addr_t TOFC_TOGGLE_OFS = 12'h00C;

  localparam tofc_tally_t TOFC_TALLY_RST = 16'h0000;
  localparam tofc_tally_t TOFC_TALLY_ONE = 16'h0001;
  localparam tofc_word_t TOFC_WORD_ZERO = 32'h0000_0000;
  localparam logic [15:0] TOFC_UPPER_ZERO = 16'h0000;
  localparam logic [TOFC_LANES-1:0] TOFC_NO_LANES = 2'h0;
  localparam logic [TOFC_LANES-1:0] TOFC_ALL_LANES = 2'h3;

  typedef enum logic [1:0] {
    TOFC_OP_WRITE = 2'b00,
    TOFC_OP_CLEAR = 2'b01,
    TOFC_OP_SET = 2'b11,
    TOFC_OP_TOGGLE = 2'b10
  } tofc_op_t;
endpackage

// file: hw/tofc_stat_counter.sv
// transmitted-ok frame statistics register with apb slave
// assumes tx_frame_ok and rd_lane_en come from logic on sys_clk
// every access answers in the cycle after its setup, with no wait states
`timescale 1ns/100ps
module tofc_stat_counter
  import tofc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [TOFC_ADDR_W-1:0] paddr,
  input wire logic [TOFC_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [TOFC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // read byte lanes, held with the apb read request
  input wire logic [TOFC_LANES-1:0] rd_lane_en,
  // transmit engine
  input wire logic tx_frame_ok,
  // live tally
  output logic [TOFC_TALLY_W-1:0] tx_ok_frame_tally
);

  logic rst_meta_b;
  logic rst_sync_b;
  tofc_tally_t tally_r, tally_nxt;
  tofc_word_t prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic setup;
  logic done;
  logic hit_stat, hit_alias, mapped;
  tofc_op_t op;
  tofc_tally_t lane_mask;
  tofc_tally_t base;

  // reset release through two flops; assertion is immediate
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  assign setup = psel && !penable;
  assign done = psel && penable && pready_r;
  assign hit_stat = (paddr == TOFC_STAT_OFS);
  assign hit_alias = (paddr == TOFC_CLEAR_OFS) || (paddr == TOFC_SET_OFS)
    || (paddr == TOFC_TOGGLE_OFS);
  assign mapped = hit_stat || hit_alias;

  always_comb begin
    unique case (paddr)
      TOFC_CLEAR_OFS: op = TOFC_OP_CLEAR;
      TOFC_SET_OFS: op = TOFC_OP_SET;
      TOFC_TOGGLE_OFS: op = TOFC_OP_TOGGLE;
      default: op = TOFC_OP_WRITE;
    endcase
  end

  // only the two low byte lanes reach storage; upper strobes are dropped
  for (genvar g = 0; g < TOFC_LANES; g++) begin : g_lane
    assign lane_mask[g*TOFC_LANE_W +: TOFC_LANE_W] = {TOFC_LANE_W{pstrb[g]}};
  end

  // software action first, then the frame event on top so no frame is lost
  always_comb begin
    base = tally_r;
    if (done && mapped && pwrite) begin
      unique case (op)
        TOFC_OP_WRITE: base = (tally_r & ~lane_mask)
          | (pwdata[TOFC_TALLY_W-1:0] & lane_mask);
        TOFC_OP_CLEAR: base = tally_r & ~(pwdata[TOFC_TALLY_W-1:0] & lane_mask);
        TOFC_OP_SET: base = tally_r | (pwdata[TOFC_TALLY_W-1:0] & lane_mask);
        TOFC_OP_TOGGLE: base = tally_r ^ (pwdata[TOFC_TALLY_W-1:0] & lane_mask);
      endcase
    end else if (done && hit_stat && !pwrite && (rd_lane_en != TOFC_NO_LANES)) begin
      base = TOFC_TALLY_RST;
    end
    // wraps on overflow; receive side has no path in here
    tally_nxt = tx_frame_ok ? base + TOFC_TALLY_ONE : base;
  end

  // answer one cycle after setup; read data is the value the access will clear
  always_comb begin
    pready_nxt = setup;
    pslverr_nxt = setup && !mapped;
    prdata_nxt = prdata_r;
    if (setup) begin
      prdata_nxt = TOFC_WORD_ZERO;
      if (!pwrite && hit_stat) begin
        prdata_nxt = {TOFC_UPPER_ZERO, tally_nxt};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tally_r <= TOFC_TALLY_RST;
      prdata_r <= TOFC_WORD_ZERO;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      tally_r <= tally_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tx_ok_frame_tally = tally_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_b);

  logic sw_idle;
  assign sw_idle = !(done && mapped);

  // frame counting and read clearing
  chk_upper_zero: assert property (prdata_r[TOFC_DATA_W-1:TOFC_TALLY_W] == TOFC_UPPER_ZERO)
    else $error("upper half of read data not zero");

  chk_tally_inc: assert property (sw_idle && tx_frame_ok
    |=> tally_r == $past(tally_r) + TOFC_TALLY_ONE)
    else $error("tally did not step by one on a good frame");

  chk_tally_hold: assert property (sw_idle && !tx_frame_ok |=> $stable(tally_r))
    else $error("tally changed without a transmitted frame");

  chk_read_clear: assert property (done && hit_stat && !pwrite
    && rd_lane_en != TOFC_NO_LANES && !tx_frame_ok |=> tally_r == TOFC_TALLY_RST)
    else $error("read did not clear the tally");

  chk_read_keep: assert property (done && hit_stat && !pwrite
    && rd_lane_en == TOFC_NO_LANES && !tx_frame_ok |=> $stable(tally_r))
    else $error("read with no lanes disturbed the tally");

  chk_keep_frame: assert property (done && hit_stat && !pwrite
    && rd_lane_en == TOFC_NO_LANES && tx_frame_ok
    |=> tally_r == $past(tally_r) + TOFC_TALLY_ONE)
    else $error("frame lost during a read with no lanes");

  chk_read_value: assert property (done && hit_stat && !pwrite
    |-> prdata_r[TOFC_TALLY_W-1:0] == tally_r)
    else $error("read data differs from tally");

  chk_clear_after: assert property (done && hit_stat && !pwrite
    && rd_lane_en != TOFC_NO_LANES && tx_frame_ok |=> tally_r == TOFC_TALLY_ONE)
    else $error("frame lost during read clear");

  // bus timing and refused addresses
  chk_ready_slot: assert property (setup |=> pready_r ##1 !pready_r)
    else $error("ready not a single cycle after setup");

  chk_err_unmapped: assert property (setup && !mapped |=> pslverr_r && pready_r)
    else $error("unmapped access not refused");

  chk_err_quiet: assert property (setup && mapped |=> !pslverr_r)
    else $error("mapped access flagged as error");

  chk_ready_cause: assert property (pready_r |-> $past(setup))
    else $error("ready without a setup cycle");

  chk_err_pair: assert property (pslverr_r |-> pready_r)
    else $error("error flag without ready");

  chk_rdata_hold: assert property (!setup |=> $stable(prdata_r))
    else $error("read data moved outside a setup cycle");

  chk_write_rdata: assert property (setup && pwrite |=> prdata_r == TOFC_WORD_ZERO)
    else $error("write left read data nonzero");

  // software actions on the tally
  chk_alias_read: assert property (setup && !pwrite && hit_alias
    |=> prdata_r == TOFC_WORD_ZERO)
    else $error("alias word did not read as zero");

  chk_alias_keep: assert property (done && hit_alias && !pwrite && !tx_frame_ok
    |=> $stable(tally_r))
    else $error("read of an alias word disturbed the tally");

  chk_unmapped_keep: assert property (done && !mapped && !tx_frame_ok
    |=> $stable(tally_r))
    else $error("unmapped access changed the tally");

  chk_write_load: assert property (done && hit_stat && pwrite
    && pstrb[TOFC_LANES-1:0] == TOFC_ALL_LANES && !tx_frame_ok
    |=> tally_r == $past(pwdata[TOFC_TALLY_W-1:0]))
    else $error("full write did not load the tally");

  chk_lane_none: assert property (done && hit_stat && pwrite
    && pstrb[TOFC_LANES-1:0] == TOFC_NO_LANES && !tx_frame_ok |=> $stable(tally_r))
    else $error("write with no low lanes changed the tally");

  chk_set_alias: assert property (done && pwrite && paddr == TOFC_SET_OFS
    && pstrb[TOFC_LANES-1:0] == TOFC_ALL_LANES && !tx_frame_ok
    |=> tally_r == ($past(tally_r) | $past(pwdata[TOFC_TALLY_W-1:0])))
    else $error("set alias did not set the tally bits");

  chk_clear_alias: assert property (done && pwrite && paddr == TOFC_CLEAR_OFS
    && pstrb[TOFC_LANES-1:0] == TOFC_ALL_LANES && !tx_frame_ok
    |=> tally_r == ($past(tally_r) & ~$past(pwdata[TOFC_TALLY_W-1:0])))
    else $error("clear alias did not clear the tally bits");

  chk_toggle_alias: assert property (done && pwrite && paddr == TOFC_TOGGLE_OFS
    && pstrb[TOFC_LANES-1:0] == TOFC_ALL_LANES && !tx_frame_ok
    |=> tally_r == ($past(tally_r) ^ $past(pwdata[TOFC_TALLY_W-1:0])))
    else $error("toggle alias did not invert the tally bits");

  cov_read_clear: cover property (done && hit_stat && !pwrite && tally_r != TOFC_TALLY_RST);
  cov_clear_race: cover property (done && hit_stat && !pwrite && tx_frame_ok);
  cov_alias_set: cover property (done && pwrite && op == TOFC_OP_SET);
  cov_unmapped: cover property (pslverr_r);
  cov_frame_wrap: cover property (tx_frame_ok && (&tally_r));

endmodule

// file: tb/tx_ok_frame_counter_test.sv
// self-checking bench for the transmitted-ok frame statistics counter
// waits on pready for every apb answer; frame pulse on the same clock
`timescale 1ns/100ps
module tx_ok_frame_counter_test;
  import tofc_pkg::*;
  typedef struct packed {
    logic [3:0] ntx;
    logic wr;
    logic [11:0] adr;
    logic [31:0] wd;
    logic [1:0] stb;
    logic [1:0] ln;
    logic [31:0] q;
    logic err;
  } tofc_row_t;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [1:0] rd_lane_en = 2'h0;
  logic tx_frame_ok = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] tx_ok_frame_tally;
  logic [31:0] rd_q;
  logic rd_e;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  tofc_row_t rows [11];
  tofc_stat_counter i_tofc_stat_counter (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rd_lane_en(rd_lane_en),
    .tx_frame_ok(tx_frame_ok), .tx_ok_frame_tally(tx_ok_frame_tally));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one idle cycle after release keeps drivers from double-assigning
  task automatic apb(logic wr, logic [11:0] adr, logic [31:0] wd, logic [1:0] stb,
                     logic [1:0] ln);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    pstrb <= {2'h0, stb};
    rd_lane_en <= ln;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    rd_lane_en <= 2'h0;
    @(posedge sys_clk);
  endtask
  task automatic pulses(int n);
    repeat (n) begin
      tx_frame_ok <= 1'b1;
      @(posedge sys_clk);
    end
    tx_frame_ok <= 1'b0;
    @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    // alias rows go through clear/set/invert words, as software should
    rows = '{'{4'h3, 1'b0, 12'h000, 32'h0000_0000, 2'h0, 2'h3, 32'h0000_0003, 1'b0},
      '{4'h0, 1'b0, 12'h000, 32'h0000_0000, 2'h0, 2'h3, 32'h0000_0000, 1'b0},
      '{4'h2, 1'b0, 12'h000, 32'h0000_0000, 2'h0, 2'h0, 32'h0000_0002, 1'b0},
      '{4'h0, 1'b1, 12'h000, 32'hABCD_1234, 2'h1, 2'h0, 32'h0000_0000, 1'b0},
      '{4'h0, 1'b1, 12'h008, 32'h0000_0F00, 2'h3, 2'h0, 32'h0000_0000, 1'b0},
      '{4'h0, 1'b1, 12'h004, 32'h0000_0004, 2'h3, 2'h0, 32'h0000_0000, 1'b0},
      '{4'h0, 1'b1, 12'h00C, 32'h0000_FFFF, 2'h3, 2'h0, 32'h0000_0000, 1'b0},
      '{4'h0, 1'b0, 12'h008, 32'h0000_0000, 2'h0, 2'h3, 32'h0000_0000, 1'b0},
      '{4'h0, 1'b0, 12'h000, 32'h0000_0000, 2'h0, 2'h2, 32'h0000_F0CF, 1'b0},
      '{4'h0, 1'b0, 12'h010, 32'h0000_0000, 2'h0, 2'h3, 32'h0000_0000, 1'b1},
      '{4'h0, 1'b0, 12'h000, 32'h0000_0000, 2'h0, 2'h1, 32'h0000_0000, 1'b0}};
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("tally after reset", {16'h0000, tx_ok_frame_tally}, 32'h0000_0000);
    foreach (rows[i]) begin
      pulses(int'(rows[i].ntx));
      apb(rows[i].wr, rows[i].adr, rows[i].wd, rows[i].stb, rows[i].ln);
      if (!rows[i].wr) check("read data", rd_q, rows[i].q);
      check("slave error", {31'h0000_0000, rd_e}, {31'h0000_0000, rows[i].err});
      $display("row %0d done", i);
    end
    apb(1'b1, 12'h000, 32'h0000_FFFF, 2'h3, 2'h0);
    pulses(1);
    check("tally wrap", {16'h0000, tx_ok_frame_tally}, 32'h0000_0000);
    pulses(2);
    // frame lands in the same cycle as the clearing read
    fork
      apb(1'b0, 12'h000, 32'h0000_0000, 2'h0, 2'h3);
      begin
        @(posedge sys_clk);
        tx_frame_ok <= 1'b1;
        @(posedge sys_clk);
        tx_frame_ok <= 1'b0;
      end
    join
    check("read before clear", rd_q, 32'h0000_0002);
    check("frame kept", {16'h0000, tx_ok_frame_tally}, 32'h0000_0001);
    $display("overlap test done");
    pulses(3);
    check("tally before reset", {16'h0000, tx_ok_frame_tally}, 32'h0000_0004);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("mid-run reset", {16'h0000, tx_ok_frame_tally}, 32'h0000_0000);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    pulses(2);
    // a write with no low strobes must leave the count alone
    apb(1'b1, 12'h000, 32'h0000_FFFF, 2'h0, 2'h0);
    apb(1'b0, 12'h000, 32'h0000_0000, 2'h0, 2'h3);
    check("count after reset", rd_q, 32'h0000_0002);
    $display("reset test done");
    summarize();
  end
endmodule
